// File: design/spi_status_params.svh
`ifndef SPI_STATUS_PARAMS_SVH
`define SPI_STATUS_PARAMS_SVH
`define WORD_BITS   8
`define FIFO_DEPTH  16
`define REG_CTRL    8'h00
`define REG_STATUS  8'h04
`define REG_DATA    8'h08
`define CTRL_ON     15
`define CTRL_ENH    3
`define CTRL_FRM    2
`define CNT_BITS    5
`define ST_RXCNT    24
`define ST_TXCNT    16
`define ST_FRAME_ERROR_FLAG   12
`define ST_BUSY     11
`define ST_TUR      8
`define ST_SHIFTER_EMPTY_FLAG     7
`define ST_ROV      6
`define ST_RBE      5
`define ST_TBE      3
`define ST_TBF      1
`define ST_RBF      0
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define LINK_PINS_IDLE 3'h1
`endif

// File: design/spi_status_pkg.sv
package spi_status_pkg;
  typedef enum logic {
    LINK_IDLE,
    LINK_SHIFT
  } link_state_t;

  typedef struct packed {
    logic on;
    logic enh;
    logic frm;
  } ctrl_t;
endpackage

// File: design/spi_link_if.sv
`timescale 1ns/1ps
interface spi_link_if #(
  parameter int W = 8
) ();
  logic         en;
  logic         framed;
  logic         tx_valid;
  logic [W-1:0] tx_word;
  logic         tx_take;
  logic         rx_done;
  logic [W-1:0] rx_word;
  logic         busy;
  logic         shifter_empty;
  logic         frame_err;
  logic         underrun;

  modport core (
    output en, framed, tx_valid, tx_word,
    input  tx_take, rx_done, rx_word, busy, shifter_empty, frame_err,
    input  underrun
  );
  modport shifter (
    input  en, framed, tx_valid, tx_word,
    output tx_take, rx_done, rx_word, busy, shifter_empty, frame_err,
    output underrun
  );
endinterface

// File: design/spi_shifter.sv
`timescale 1ns/1ps
`include "spi_status_params.svh"
module spi_shifter #(
  parameter int W = 8
) (
  // system
  input  wire logic    sys_clk,
  input  wire logic    rstn,
  // serial pins
  input  wire logic    sck,
  input  wire logic    sdi,
  input  wire logic    ss_n,
  output logic         sdo,
  output logic         sdo_oe,
  // core side
  spi_link_if.shifter  lk
);
  localparam int CW = $clog2(W);

  typedef struct packed {
    logic [2:0]                  s1;
    logic [2:0]                  s2;
    logic [2:0]                  s3;
    logic [2:0]                  pin;
    spi_status_pkg::link_state_t st;
    logic [CW-1:0]               cnt;
    logic [W-1:0]                txsh;
    logic [W-1:0]                rxsh;
    logic [W-1:0]                rx_word;
    logic                        loaded;
    logic                        sdo;
    logic                        take;
    logic                        done;
    logic                        ferr;
    logic                        urun;
  } sh_t;

  sh_t s_q;
  sh_t s_d;
  logic rise;
  logic fall;
  logic sel;
  logic desel;

  // next word into shifter, zeros when none waits, plus underrun in framed mode
  function automatic sh_t load(input sh_t s);
    sh_t r;
    r = s;
    r.take   = lk.tx_valid;
    r.loaded = lk.tx_valid;
    r.txsh   = lk.tx_valid ? lk.tx_word : '0;
    r.urun   = !lk.tx_valid && lk.framed;
    return r;
  endfunction

  always_comb begin
    s_d      = s_q;
    s_d.take = 1'b0;
    s_d.done = 1'b0;
    s_d.ferr = 1'b0;
    s_d.urun = 1'b0;
    s_d.s1   = {sck, sdi, ss_n};
    s_d.s2   = s_q.s1;
    s_d.s3   = s_q.s2;
    s_d.pin  = (s_q.s2 & s_q.s3) | (s_q.pin & (s_q.s2 ^ s_q.s3));
    rise     = s_d.pin[2] && !s_q.pin[2];
    fall     = !s_d.pin[2] && s_q.pin[2];
    sel      = !s_d.pin[0] && s_q.pin[0];
    desel    = s_d.pin[0] && !s_q.pin[0];
    unique case (s_q.st)
      spi_status_pkg::LINK_IDLE: begin
        s_d.loaded = 1'b0;
        if (lk.en && sel) begin
          s_d     = load(s_d);
          s_d.cnt = '0;
          s_d.sdo = s_d.txsh[W-1];
          s_d.st  = spi_status_pkg::LINK_SHIFT;
        end
      end
      spi_status_pkg::LINK_SHIFT: begin
        if (!lk.en) begin
          s_d.st = spi_status_pkg::LINK_IDLE;
        end else if (desel) begin
          s_d.ferr = lk.framed && (s_q.cnt != '0);
          s_d.st   = spi_status_pkg::LINK_IDLE;
        end else if (rise) begin
          s_d.rxsh = {s_q.rxsh[W-2:0], s_d.pin[1]};
          if (s_q.cnt == CW'(W - 1)) begin
            s_d.done    = 1'b1;
            s_d.rx_word = s_d.rxsh;
            s_d.cnt     = '0;
            s_d         = load(s_d);
          end else begin
            s_d.cnt = s_q.cnt + 1'b1;
          end
        end else if (fall) begin
          if (s_q.cnt != '0) begin
            s_d.txsh = {s_q.txsh[W-2:0], 1'b0};
          end
          s_d.sdo = s_d.txsh[W-1];
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{s1: `LINK_PINS_IDLE, s2: `LINK_PINS_IDLE,
               s3: `LINK_PINS_IDLE, pin: `LINK_PINS_IDLE,
               st: spi_status_pkg::LINK_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sdo              = s_q.sdo;
  assign sdo_oe           = s_q.st == spi_status_pkg::LINK_SHIFT;
  assign lk.tx_take       = s_q.take;
  assign lk.rx_done       = s_q.done;
  assign lk.rx_word       = s_q.rx_word;
  assign lk.busy          = s_q.st == spi_status_pkg::LINK_SHIFT;
  assign lk.shifter_empty = !s_q.loaded;
  assign lk.frame_err     = s_q.ferr;
  assign lk.underrun      = s_q.urun;
endmodule

// File: design/spi_status_flags.sv
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "spi_status_params.svh"

// Overview of operation
// - status bits 28-24 give the receive buffer element count
// - status bits 20-16 give the transmit buffer element count
// - frame error flag set by hardware in framed mode, cleared by software
// - activity bit high while a transaction runs, low when idle
// - underrun flag set when transmit buffer is empty in framed mode
// - underrun stays set until written zero or unit disabled
// - shifter empty bit is one when the shift register holds nothing
// - word arriving while receive buffer full sets overflow and is dropped
// - overflow set only by hardware, cleared by zero write or disable
// - receive empty bit high exactly when read and write pointers match
// - unimplemented status bits read as zero
module spi_status_flags #(
  parameter int AW    = 8,
  parameter int W     = `WORD_BITS,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // system
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  // axi4-lite write address
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  // axi4-lite write data
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  // axi4-lite write response
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  // axi4-lite read address
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  // axi4-lite read data
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  // serial link
  input  wire logic          sck,
  input  wire logic          sdi,
  input  wire logic          ss_n,
  output logic               sdo,
  output logic               sdo_oe
);
  localparam int PW = $clog2(DEPTH) + 1;
  localparam int IW = PW - 1;

  typedef struct packed {
    logic                      aw_hold;
    logic [AW-1:0]             aw_addr;
    logic                      w_hold;
    logic [31:0]               w_data;
    logic [3:0]                w_strb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    spi_status_pkg::ctrl_t     ctrl;
    logic                      frm_err;
    logic                      tur;
    logic                      rov;
    logic [PW-1:0]             tx_wr;
    logic [PW-1:0]             tx_rd;
    logic [PW-1:0]             rx_wr;
    logic [PW-1:0]             rx_rd;
    logic [DEPTH-1:0][W-1:0]   tx_mem;
    logic [DEPTH-1:0][W-1:0]   rx_mem;
  } state_t;

  state_t        s_q;
  state_t        s_d;
  logic [PW-1:0] cap;
  logic [PW-1:0] tx_cnt;
  logic [PW-1:0] rx_cnt;
  logic [PW-1:0] rx_cnt_d;
  logic          tx_full;
  logic          tx_empty;
  logic          rx_full;
  logic          rx_empty;
  logic          do_wr;
  logic          do_rd;
  logic [31:0]   wmask;
  logic [31:0]   stat_w;
  logic [31:0]   ctrl_w;
  logic [31:0]   data_w;
  logic          aw_take;
  logic          w_take;
  logic          b_done;
  logic          r_done;
  logic          wr_ctrl;
  logic          wr_stat;
  logic          wr_data;
  logic          wr_miss;
  logic          rd_ctrl;
  logic          rd_stat;
  logic          rd_data;
  logic          rd_miss;
  logic          rd_pop;
  logic          tx_push;
  logic          rx_push;
  logic          clr_frm;
  logic          clr_tur;
  logic          clr_rov;
  logic          set_frm;
  logic          set_tur;
  logic          set_rov;
  logic [31:0]   rd_word;
  logic [1:0]    rd_resp;

  spi_link_if #(.W(W)) lk ();

  spi_shifter #(
    .W (W)
  ) u_shifter (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .sck     (sck),
    .sdi     (sdi),
    .ss_n    (ss_n),
    .sdo     (sdo),
    .sdo_oe  (sdo_oe),
    .lk      (lk)
  );

  // buffers hold one word unless enhanced mode opens the full depth
  assign cap      = s_q.ctrl.enh ? PW'(DEPTH) : PW'(1);
  assign tx_cnt   = s_q.tx_wr - s_q.tx_rd;
  assign rx_cnt   = s_q.rx_wr - s_q.rx_rd;
  assign tx_full  = tx_cnt == cap;
  assign tx_empty = tx_cnt == '0;
  assign rx_full  = rx_cnt == cap;
  assign rx_empty = s_q.rx_rd == s_q.rx_wr;

  assign lk.en       = s_q.ctrl.on;
  assign lk.framed   = s_q.ctrl.frm;
  assign lk.tx_valid = !tx_empty;
  assign lk.tx_word  = s_q.tx_mem[s_q.tx_rd[IW-1:0]];

  // byte lane strobes widened to a bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{s_q.w_strb[b]}};
    end
  end

  assign do_wr = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
  assign do_rd = arvalid && !s_q.rvalid;

  assign aw_take = awvalid && awready;
  assign w_take  = wvalid && wready;
  assign b_done  = s_q.bvalid && bready;
  assign r_done  = s_q.rvalid && rready;

  // register select for the held write and the offered read
  always_comb begin
    wr_ctrl = s_q.aw_addr == AW'(`REG_CTRL);
    wr_stat = s_q.aw_addr == AW'(`REG_STATUS);
    wr_data = s_q.aw_addr == AW'(`REG_DATA);
    wr_miss = !(wr_ctrl || wr_stat || wr_data);
    rd_ctrl = araddr == AW'(`REG_CTRL);
    rd_stat = araddr == AW'(`REG_STATUS);
    rd_data = araddr == AW'(`REG_DATA);
    rd_miss = !(rd_ctrl || rd_stat || rd_data);
  end

  // software side effects: zero writes clear, data reads pop
  always_comb begin
    clr_frm = do_wr && wr_stat && wmask[`ST_FRAME_ERROR_FLAG]
              && !s_q.w_data[`ST_FRAME_ERROR_FLAG];
    clr_tur = do_wr && wr_stat && wmask[`ST_TUR]
              && !s_q.w_data[`ST_TUR];
    clr_rov = do_wr && wr_stat && wmask[`ST_ROV]
              && !s_q.w_data[`ST_ROV];
    tx_push = do_wr && wr_data && s_q.w_strb[0] && !tx_full;
    rd_pop  = do_rd && rd_data && !rx_empty;
  end

  // hardware side effects from the shifter
  always_comb begin
    set_frm = lk.frame_err;
    set_tur = lk.underrun;
    set_rov = lk.rx_done && rx_cnt_d == cap;
    rx_push = lk.rx_done && !set_rov;
  end

  // read word and response for the offered address
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = `RESP_OKAY;
    if (rd_ctrl) begin
      rd_word = ctrl_w;
    end else if (rd_stat) begin
      rd_word = stat_w;
    end else if (rd_data) begin
      rd_word = data_w;
    end else begin
      rd_resp = `RESP_SLVERR;
    end
  end

  // status word, unused positions stay zero
  always_comb begin
    stat_w = '0;
    stat_w[`ST_RXCNT +: `CNT_BITS] = `CNT_BITS'(rx_cnt);
    stat_w[`ST_TXCNT +: `CNT_BITS] = `CNT_BITS'(tx_cnt);
    stat_w[`ST_FRAME_ERROR_FLAG] = s_q.frm_err;
    stat_w[`ST_BUSY]   = lk.busy;
    stat_w[`ST_TUR]    = s_q.tur;
    stat_w[`ST_SHIFTER_EMPTY_FLAG]   = lk.shifter_empty;
    stat_w[`ST_ROV]    = s_q.rov;
    stat_w[`ST_RBE]    = rx_empty;
    stat_w[`ST_TBE]    = tx_empty;
    stat_w[`ST_TBF]    = tx_full;
    stat_w[`ST_RBF]    = rx_full;
  end

  always_comb begin
    ctrl_w            = '0;
    ctrl_w[`CTRL_ON]  = s_q.ctrl.on;
    ctrl_w[`CTRL_ENH] = s_q.ctrl.enh;
    ctrl_w[`CTRL_FRM] = s_q.ctrl.frm;
  end

  assign data_w = rx_empty ? 32'h0000_0000
                           : 32'(s_q.rx_mem[s_q.rx_rd[IW-1:0]]);

  always_comb begin
    s_d = s_q;
    // address and data captured independently
    if (aw_take) begin
      s_d.aw_hold = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (w_take) begin
      s_d.w_hold = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if (b_done) begin
      s_d.bvalid = 1'b0;
    end
    if (r_done) begin
      s_d.rvalid = 1'b0;
    end
    // register write
    if (do_wr) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = `RESP_OKAY;
      if (wr_miss) begin
        s_d.bresp = `RESP_SLVERR;
      end
      if (wr_ctrl) begin
        if (wmask[`CTRL_ON]) begin
          s_d.ctrl.on = s_q.w_data[`CTRL_ON];
        end
        if (wmask[`CTRL_ENH]) begin
          s_d.ctrl.enh = s_q.w_data[`CTRL_ENH];
        end
        if (wmask[`CTRL_FRM]) begin
          s_d.ctrl.frm = s_q.w_data[`CTRL_FRM];
        end
      end
    end
    if (tx_push) begin
      s_d.tx_mem[s_q.tx_wr[IW-1:0]] = s_q.w_data[W-1:0];
      s_d.tx_wr = s_q.tx_wr + 1'b1;
    end
    // register read, a data read pops one received word
    if (do_rd) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = rd_resp;
      s_d.rdata  = rd_word;
    end
    if (rd_pop) begin
      s_d.rx_rd = s_q.rx_rd + 1'b1;
    end
    // sticky flags, a set wins over a clear in the same cycle
    if (clr_frm) begin
      s_d.frm_err = 1'b0;
    end
    if (clr_tur) begin
      s_d.tur = 1'b0;
    end
    if (clr_rov) begin
      s_d.rov = 1'b0;
    end
    if (set_frm) begin
      s_d.frm_err = 1'b1;
    end
    if (set_tur) begin
      s_d.tur = 1'b1;
    end
    if (set_rov) begin
      s_d.rov = 1'b1;
    end
    // link events on the buffers
    if (lk.tx_take) begin
      s_d.tx_rd = s_q.tx_rd + 1'b1;
    end
    if (rx_push) begin
      s_d.rx_mem[s_q.rx_wr[IW-1:0]] = lk.rx_word;
      s_d.rx_wr = s_q.rx_wr + 1'b1;
    end
    // disabled unit drops buffers and sticky flags
    if (!s_q.ctrl.on) begin
      s_d.tx_rd   = s_d.tx_wr;
      s_d.rx_rd   = s_d.rx_wr;
      s_d.frm_err = 1'b0;
      s_d.tur     = 1'b0;
      s_d.rov     = 1'b0;
    end
  end

  // fill level after this cycle's software pop
  assign rx_cnt_d = s_q.rx_wr - (do_rd && araddr == AW'(`REG_DATA)
                                 && !rx_empty ? s_q.rx_rd + 1'b1
                                              : s_q.rx_rd);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready = !s_q.aw_hold;
  assign wready  = !s_q.w_hold;
  assign bvalid  = s_q.bvalid;
  assign bresp   = s_q.bresp;
  assign arready = !s_q.rvalid;
  assign rvalid  = s_q.rvalid;
  assign rdata   = s_q.rdata;
  assign rresp   = s_q.rresp;
endmodule

// File: verification/spi_status_flags_chk.sv
`timescale 1ns/1ps
`include "spi_status_params.svh"
module spi_status_flags_chk #(
  parameter int AW = 8
) (
  // system
  input logic          sys_clk,
  input logic          rstn,
  // register bus
  input logic          awvalid,
  input logic          awready,
  input logic [AW-1:0] araddr,
  input logic          arvalid,
  input logic          arready,
  input logic [31:0]   rdata,
  input logic          rvalid,
  input logic          rready,
  // serial link
  input logic          ss_n,
  input logic          sdo_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  logic [AW-1:0] ra_q;
  logic [3:0]    hi_q;
  logic [2:0]    fl_q;
  logic          wr_q;
  logic          st;
  logic [2:0]    fl;
  assign st = rvalid && ra_q == AW'(`REG_STATUS);
  assign fl = {rdata[`ST_FRAME_ERROR_FLAG], rdata[`ST_TUR], rdata[`ST_ROV]};
  // read address, idle time, sticky flags seen last
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ra_q <= '0;
      hi_q <= 4'h0;
      fl_q <= 3'h0;
      wr_q <= 1'b0;
    end else begin
      if (arvalid && arready) ra_q <= araddr;
      if (!ss_n) hi_q <= 4'h0;
      else if (hi_q != 4'hF) hi_q <= hi_q + 4'h1;
      if (st && rready) fl_q <= fl;
      if (awvalid && awready) wr_q <= 1'b1;
      else if (st && rready) wr_q <= 1'b0;
    end
  end
  AST_RSVD_ZERO: assert property (
    st |-> {rdata[31:29], rdata[23:21], rdata[15:13], rdata[10:9],
      rdata[4], rdata[2]} == 13'h0)
    else $error("reserved bit set");
  AST_RX_EMPTY: assert property (
    st |-> rdata[`ST_RBE] == (rdata[28:24] == 5'h00))
    else $error("rx empty wrong");
  AST_TX_EMPTY: assert property (
    st |-> rdata[`ST_TBE] == (rdata[20:16] == 5'h00))
    else $error("tx empty wrong");
  AST_IDLE_BUSY: assert property (
    st && hi_q > 4'h8 |-> !rdata[`ST_BUSY])
    else $error("busy while idle");
  AST_OE_IDLE: assert property (
    hi_q > 4'h8 |-> !sdo_oe)
    else $error("driving while idle");
  AST_STICKY: assert property (
    st && !wr_q |-> (fl & fl_q) == fl_q)
    else $error("flag lost");
  AST_RD_ANS: assert property (
    arvalid && arready |=> rvalid)
    else $error("read late");
  AST_RD_HOLD: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data moved");
  cover property (st && rdata[`ST_ROV]);
  cover property (st && rdata[`ST_TUR]);
  cover property (st && rdata[`ST_BUSY]);
endmodule

bind spi_status_flags spi_status_flags_chk #(.AW(AW))
  u_spi_status_flags_chk (
  .sys_clk(sys_clk), .rstn(rstn), .awvalid(awvalid), .awready(awready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .ss_n(ss_n), .sdo_oe(sdo_oe)
);

// File: verification/spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (
  // serial pins
  output logic      sck,
  output logic      sdi,
  output logic      ss_n,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    ss_n = 1'b1;
  end
  // n bits msb first, clock still between frames
  task automatic xfer(input logic [7:0] o, input int n,
                      output logic [7:0] i);
    i = 8'h00;
    ss_n <= 1'b0;
    #100;
    for (int k = 7; k > 7 - n; k--) begin
      sdi <= o[k];
      #62.5 sck <= 1'b1;
      i = {i[6:0], sdo_oe ? sdo : 1'bx};
      #62.5 sck <= 1'b0;
    end
    ss_n <= 1'b1;
    sdi <= ~sdi;
    #100;
  endtask
endmodule

// File: verification/spi_status_flags_tb_top.sv
`timescale 1ns/1ps
`include "spi_status_params.svh"
module spi_status_flags_tb_top;
  localparam logic [31:0] ON  = 32'h1 << `CTRL_ON;
  localparam logic [31:0] ENH = 32'h1 << `CTRL_ENH;
  localparam logic [31:0] FRM = 32'h1 << `CTRL_FRM;
  logic        sys_clk, rstn;
  logic [7:0]  awaddr, araddr, got;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        sck, sdi, ss_n, sdo, sdo_oe;
  int          bad_count, n_compared;
  spi_status_flags u_spi_status_flags (
    .sys_clk(sys_clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .sck(sck),
    .sdi(sdi), .ss_n(ss_n), .sdo(sdo), .sdo_oe(sdo_oe)
  );
  spi_master_model u_spi_master_model (
    .sck(sck), .sdi(sdi), .ss_n(ss_n), .sdo(sdo), .sdo_oe(sdo_oe)
  );
  always #5 sys_clk = ~sys_clk;
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask
  // one write or one read, answer kept in rv and rr
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    logic aw, w, ar, done;
    done = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= we;
    wvalid <= we;
    bready <= we;
    arvalid <= !we;
    rready <= !we;
    while (!done) begin
      @(negedge sys_clk);
      aw = awready;
      w = wready;
      ar = arready;
      done = we ? bvalid : rvalid;
      rv = rdata;
      rr = we ? bresp : rresp;
      @(posedge sys_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (ar) arvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
  endtask
  task automatic sbit(input int b, input logic e);
    bus(1'b0, `REG_STATUS, 32'h0);
    cmp({31'h0, rv[b]}, {31'h0, e});
  endtask
  task automatic t_reset();
    bus(1'b0, `REG_STATUS, 32'h0);
    cmp(rv, 32'h000000A8);
    bus(1'b1, `REG_STATUS, 32'hFFFFFFFF);
    bus(1'b0, `REG_STATUS, 32'h0);
    cmp(rv, 32'h000000A8);
    $display("reset test done");
  endtask
  task automatic t_unmapped();
    bus(1'b1, 8'h0C, 32'h0);
    cmp({30'h0, rr}, {30'h0, `RESP_SLVERR});
    bus(1'b0, 8'h0C, 32'h0);
    cmp({rv[29:0], rr}, {30'h0, `RESP_SLVERR});
    $display("unmapped test done");
  endtask
  task automatic t_frame();
    bus(1'b1, `REG_CTRL, ON | ENH);
    bus(1'b1, `REG_DATA, 32'h3C);
    bus(1'b1, `REG_DATA, 32'h11);
    bus(1'b0, `REG_STATUS, 32'h0);
    cmp(rv & 32'hFFFFFF7F, 32'h00020020);
    fork
      u_spi_master_model.xfer(8'hA5, 8, got);
      #500 sbit(`ST_BUSY, 1'b1);
    join
    cmp({24'h0, got}, 32'h3C);
    sbit(`ST_BUSY, 1'b0);
    bus(1'b0, `REG_STATUS, 32'h0);
    cmp({27'h0, rv[28:24]}, 32'h1);
    bus(1'b0, `REG_DATA, 32'h0);
    cmp(rv, 32'hA5);
    sbit(`ST_RBE, 1'b1);
    bus(1'b1, `REG_CTRL, 32'h0);
    $display("frame test done");
  endtask
  task automatic t_overflow();
    bus(1'b1, `REG_CTRL, ON);
    u_spi_master_model.xfer(8'h81, 8, got);
    u_spi_master_model.xfer(8'h42, 8, got);
    sbit(`ST_ROV, 1'b1);
    sbit(`ST_RBF, 1'b1);
    bus(1'b1, `REG_STATUS, 32'hFFFFFFFF);
    sbit(`ST_ROV, 1'b1);
    bus(1'b0, `REG_DATA, 32'h0);
    cmp(rv, 32'h81);
    bus(1'b1, `REG_STATUS, 32'h0);
    sbit(`ST_ROV, 1'b0);
    $display("overflow test done");
  endtask
  task automatic t_framed();
    bus(1'b1, `REG_CTRL, ON | FRM);
    u_spi_master_model.xfer(8'h00, 8, got);
    sbit(`ST_TUR, 1'b1);
    u_spi_master_model.xfer(8'hF0, 4, got);
    sbit(`ST_FRAME_ERROR_FLAG, 1'b1);
    bus(1'b1, `REG_STATUS, 32'h00001000);
    sbit(`ST_TUR, 1'b0);
    sbit(`ST_FRAME_ERROR_FLAG, 1'b1);
    bus(1'b1, `REG_CTRL, 32'h0);
    bus(1'b1, `REG_CTRL, ON | FRM);
    sbit(`ST_FRAME_ERROR_FLAG, 1'b0);
    $display("framed test done");
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    wstrb = 4'hF;
    {awaddr, araddr, wdata} = 48'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_unmapped();
    t_frame();
    t_overflow();
    t_framed();
    report_and_stop();
  end
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
endmodule
